//--- src/desf_pkg.sv
// Constants, field layout and carrier types of the DMA error status flags.
// Assumes a single 250 MHz clock domain for all users of the package.
package desf_pkg;

  // Clock period and timing figures.
  localparam int CLK_PERIOD_NS = 4;
  localparam int MTO_TIME_NS   = 10_000;
  localparam int NG_TIME_MS    = 10;
  localparam int MTO_CYCLES    = MTO_TIME_NS / CLK_PERIOD_NS;
  localparam int NG_CYCLES     = NG_TIME_MS * 1_000_000 / CLK_PERIOD_NS;
  localparam int TMR_W         = 22;

  // Flag bit positions inside the status word.
  localparam int BIT_HALT  = 15;
  localparam int BIT_PGNEG = 14;
  localparam int BIT_MTO   = 7;
  localparam int BIT_PAR   = 5;
  localparam int BIT_MEM   = 4;
  localparam int BIT_LOST  = 3;
  localparam int BIT_NOGNT = 2;
  localparam int BIT_NOMEM = 0;
  localparam int FLAG_W    = 16;
  localparam int DATA_W    = 32;
  localparam int BE_W      = 4;
  localparam int LANE_W    = 8;

  // Implemented flags and the flags that own a captured error address.
  localparam logic [FLAG_W-1:0] IMPL_MASK  = 16'hc0bd;
  localparam logic [FLAG_W-1:0] CAPT_MASK  = 16'h00b1;
  localparam logic [FLAG_W-1:0] FLAG_RESET = 16'h0000;
  localparam logic [DATA_W-FLAG_W-1:0] HIGH_ZERO = 16'h0000;
  localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;

  // Kind of a processor cycle on the backplane bus.
  typedef enum logic [1:0] {
    DESF_DEMAND_RD,
    DESF_DEMAND_WR,
    DESF_IACK,
    DESF_PREFETCH
  } desf_kind_t;

  // One access request of the processor to the status register.
  typedef struct packed {
    logic              sel;
    logic              rd;
    logic              wr;
    logic              local_cpu;
    logic [BE_W-1:0]   be;
    logic [DATA_W-1:0] wdata;
  } desf_cpu_req_t;

endpackage : desf_pkg

//--- src/desf_timer.sv
// Watchdog counter that fires once when a started wait is not ended in time.
// Assumes start and stop are single-cycle pulses on the same clock.
`timescale 1ns/1ns
`default_nettype none
module desf_timer
  import desf_pkg::*;
#(
  parameter int LIMIT = 2500
)(
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic start,
  input  wire logic stop,
  output logic      expired
);

  localparam logic [TMR_W-1:0] LAST = TMR_W'(LIMIT - 1);
  localparam logic [TMR_W-1:0] ZERO = '0;

  logic             run_q;
  logic             run_d;
  logic [TMR_W-1:0] cnt_q;
  logic [TMR_W-1:0] cnt_d;

  // A new start restarts the wait; stop ends it before the limit.
  always_comb
  begin
    run_d   = run_q;
    cnt_d   = cnt_q;
    expired = 1'b0;
    if (start)
    begin
      run_d = 1'b1;
      cnt_d = ZERO;
    end
    else if (run_q && stop)
    begin
      run_d = 1'b0;
    end
    else if (run_q && cnt_q == LAST)
    begin
      run_d   = 1'b0;
      expired = 1'b1;
    end
    else if (run_q)
    begin
      cnt_d = cnt_q + TMR_W'(1);
    end
  end

  // Counter state registers.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_q <= 1'b0;
      cnt_q <= ZERO;
    end
    else
    begin
      run_q <= run_d;
      cnt_q <= cnt_d;
    end
  end

  // The expiry pulse only comes out of a running wait.
  chk_timer_run: assert property (@(posedge ref_clk) disable iff (!rst_n)
    expired |-> run_q && !start)
    else $error("timer expired while idle");

endmodule : desf_timer
`default_nettype wire

//--- src/desf_top.sv
// Sticky error status flags of the backplane bus interface.
// Assumes bus cycle, grant and memory events come from logic on ref_clk;
// the halt and power-good lines are raw backplane pins.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// - Unused bits 31:16, 13:8, 6 and 1 read as zero and software writes zero.
// - Bit 15 sets when the halt line is seen asserted while halt is enabled.
// - Bit 14 sets on power-good negation while the halt action is selected.
// - Bit 7 sets when a demand read or write gets no reply within 10 us.
// - Interrupt acknowledge and prefetch timeouts never set bit 7.
// - Bit 5 sets on a parity error answering a demand read only.
// - Bit 4 sets on a local memory read error for an outside master or miss.
// - A local memory read error seen by an outside master is reported back.
// - Bit 3 sets when an address-capturing error meets bit 7, 5, 4 or 0 set.
// - Bit 2 sets when a demand cycle gets no bus grant within 10 ms.
// - Bit 0 sets when a DMA transfer reaches nonexistent memory.
// - Writing one clears a flag and the I/O reset write clears all flags.
// - All flags clear at power-up and on power-good negation while halted.
// - Writing zero leaves a flag alone and flags only set on events.
// - Byte, word and longword accesses are taken from the local cpu only.
// - With halt enabled the halt line halts the cpu, otherwise it is inert.
module desf_top
  import desf_pkg::*;
#(
  parameter int NO_GRANT_CYCLES = NG_CYCLES
)(
  input  wire logic          ref_clk,
  input  wire logic          rst_n,
  input  wire desf_cpu_req_t cpu_req,
  output logic [DATA_W-1:0]  rd_data_q,
  output logic               cpu_ack_q,
  output logic               cpu_err_q,
  input  wire logic          backplane_halt_line,
  input  wire logic          backplane_power_good,
  input  wire logic          halt_line_enable,
  input  wire logic          pg_action_halt,
  input  wire logic          cpu_halted,
  input  wire logic          io_reset_write,
  input  wire logic          mst_start,
  input  wire desf_kind_t    mst_kind,
  input  wire logic          mst_reply,
  input  wire logic          mst_parity_err,
  input  wire logic          grant_req,
  input  wire desf_kind_t    grant_kind,
  input  wire logic          bus_grant,
  input  wire logic          mem_read_err,
  input  wire logic          mem_err_ext_master,
  input  wire logic          mem_err_lmgh,
  input  wire logic          dma_no_mem,
  output logic               cpu_halt_req_q,
  output logic               interprocessor_comm_reg_err_q
);

  logic halt_meta_q, halt_s_q, pg_meta_q, pg_s_q, pg_old_q;
  logic mst_demand_q, mst_dem_rd_q, gnt_demand_q;
  logic mst_demand_d, mst_dem_rd_d, gnt_demand_d;
  logic mto_exp, ng_exp, pg_neg, clr_all, access, wr_ok;
  logic [FLAG_W-1:0] flags_q, flags_d, set_vec, clr_vec, lane_mask;
  logic [DATA_W-1:0] rd_data_d;
  logic cpu_ack_d, cpu_err_d, halt_req_d, ipc_err_d;

  // Backplane pins pass two flops; only the second flop and the power-good edge flop are read further.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      halt_meta_q <= 1'b0;
      halt_s_q    <= 1'b0;
      pg_meta_q   <= 1'b1;
      pg_s_q      <= 1'b1;
      pg_old_q    <= 1'b1;
    end
    else
    begin
      halt_meta_q <= backplane_halt_line;
      halt_s_q    <= halt_meta_q;
      pg_meta_q   <= backplane_power_good;
      pg_s_q      <= pg_meta_q;
      pg_old_q    <= pg_s_q;
    end
  end

  assign pg_neg = pg_old_q && !pg_s_q;

  // Watchdogs for the reply of a master cycle and for the bus grant.
  desf_timer #(.LIMIT(MTO_CYCLES)) u_reply_tmr (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (mst_start),
    .stop    (mst_reply),
    .expired (mto_exp)
  );

  desf_timer #(.LIMIT(NO_GRANT_CYCLES)) u_grant_tmr (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .start   (grant_req),
    .stop    (bus_grant),
    .expired (ng_exp)
  );

  // The cycle kind is held so that the outcome is judged by its origin.
  always_comb
  begin
    mst_demand_d = mst_demand_q;
    mst_dem_rd_d = mst_dem_rd_q;
    gnt_demand_d = gnt_demand_q;
    if (mst_start)
    begin
      mst_demand_d = (mst_kind == DESF_DEMAND_RD) ||
                     (mst_kind == DESF_DEMAND_WR);
      mst_dem_rd_d = (mst_kind == DESF_DEMAND_RD);
    end
    if (grant_req)
    begin
      gnt_demand_d = (grant_kind == DESF_DEMAND_RD) ||
                     (grant_kind == DESF_DEMAND_WR);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mst_demand_q <= 1'b0;
      mst_dem_rd_q <= 1'b0;
      gnt_demand_q <= 1'b0;
    end
    else
    begin
      mst_demand_q <= mst_demand_d;
      mst_dem_rd_q <= mst_dem_rd_d;
      gnt_demand_q <= gnt_demand_d;
    end
  end

  // Register access: only the local cpu is served, any byte lane mix.
  assign access    = cpu_req.sel && (cpu_req.rd || cpu_req.wr);
  assign wr_ok     = access && cpu_req.wr && cpu_req.local_cpu;
  assign lane_mask = {{LANE_W{cpu_req.be[1]}}, {LANE_W{cpu_req.be[0]}}};
  assign clr_all   = io_reset_write || (pg_neg && cpu_halted);

  // Event vector; the lost bit looks at flags already holding an address.
  always_comb
  begin
    set_vec            = FLAG_RESET;
    set_vec[BIT_HALT]  = halt_s_q && halt_line_enable;
    set_vec[BIT_PGNEG] = pg_neg && pg_action_halt;
    set_vec[BIT_MTO]   = mto_exp && mst_demand_q;
    set_vec[BIT_PAR]   = mst_parity_err && mst_dem_rd_q;
    set_vec[BIT_MEM]   = mem_read_err &&
                         (mem_err_ext_master || mem_err_lmgh);
    set_vec[BIT_NOGNT] = ng_exp && gnt_demand_q;
    set_vec[BIT_NOMEM] = dma_no_mem;
    set_vec[BIT_LOST]  = ((set_vec & CAPT_MASK) != FLAG_RESET) &&
                         ((flags_q & CAPT_MASK) != FLAG_RESET);
  end

  // Write-one clear; zeros and unused positions leave the flags alone.
  always_comb
  begin
    clr_vec = FLAG_RESET;
    if (wr_ok)
    begin
      clr_vec = cpu_req.wdata[FLAG_W-1:0] & lane_mask & IMPL_MASK;
    end
    if (clr_all)
    begin
      flags_d = FLAG_RESET;
    end
    else
    begin
      // Set beats clear so an event arriving with its clear survives.
      flags_d = ((flags_q & ~clr_vec) | set_vec) & IMPL_MASK;
    end
  end

  // Read data, access answer, halt request and the outside master report.
  always_comb
  begin
    rd_data_d  = rd_data_q;
    cpu_ack_d  = access && cpu_req.local_cpu;
    cpu_err_d  = access && !cpu_req.local_cpu;
    halt_req_d = halt_s_q && halt_line_enable;
    ipc_err_d  = mem_read_err && mem_err_ext_master;
    if (access && cpu_req.rd && cpu_req.local_cpu)
    begin
      rd_data_d = {HIGH_ZERO, flags_q & IMPL_MASK};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_q                       <= FLAG_RESET;
      rd_data_q                     <= DATA_RESET;
      cpu_ack_q                     <= 1'b0;
      cpu_err_q                     <= 1'b0;
      cpu_halt_req_q                <= 1'b0;
      interprocessor_comm_reg_err_q <= 1'b0;
    end
    else
    begin
      flags_q                       <= flags_d;
      rd_data_q                     <= rd_data_d;
      cpu_ack_q                     <= cpu_ack_d;
      cpu_err_q                     <= cpu_err_d;
      cpu_halt_req_q                <= halt_req_d;
      interprocessor_comm_reg_err_q <= ipc_err_d;
    end
  end

  // Checks of the flag behaviour against its causes.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  chk_unused_read_zero: assert property (
    cpu_ack_q |-> (rd_data_q & ~{HIGH_ZERO, IMPL_MASK}) == DATA_RESET)
    else $error("unused status bit read as one");
  chk_halt_sets_flag: assert property (
    halt_s_q && halt_line_enable && !clr_all |=> flags_q[BIT_HALT])
    else $error("halt flag missed");
  chk_pgneg_sets_flag: assert property (
    pg_neg && pg_action_halt && !clr_all |=> flags_q[BIT_PGNEG])
    else $error("power-good flag missed");
  chk_mto_demand_sets: assert property (
    mto_exp && mst_demand_q && !clr_all |=> flags_q[BIT_MTO])
    else $error("master timeout flag missed");
  chk_mto_other_quiet: assert property (
    mto_exp && !mst_demand_q && !flags_q[BIT_MTO] |=> !flags_q[BIT_MTO])
    else $error("master timeout flag set for iack or prefetch");
  chk_parity_demand_rd: assert property (
    mst_parity_err && !clr_all |=> flags_q[BIT_PAR] ==
    (($past(flags_q[BIT_PAR]) && !$past(clr_vec[BIT_PAR]))
    || $past(mst_dem_rd_q)))
    else $error("parity flag wrong");
  chk_mem_err_report: assert property (
    mem_read_err && mem_err_ext_master && !clr_all
    |=> flags_q[BIT_MEM] && interprocessor_comm_reg_err_q)
    else $error("memory error not flagged or reported");
  chk_lost_error_set: assert property (
    dma_no_mem && flags_q[BIT_MEM] && !clr_all |=> flags_q[BIT_LOST])
    else $error("lost error flag missed");
  chk_no_grant_flag: assert property (
    ng_exp && !clr_all |=> flags_q[BIT_NOGNT] ==
    (($past(flags_q[BIT_NOGNT]) && !$past(clr_vec[BIT_NOGNT]))
    || $past(gnt_demand_q)))
    else $error("no grant flag wrong");
  chk_nomem_sets_flag: assert property (
    dma_no_mem && !clr_all |=> flags_q[BIT_NOMEM])
    else $error("nonexistent memory flag missed");
  chk_io_reset_clears: assert property (
    clr_all |=> flags_q == FLAG_RESET)
    else $error("flags survived a clear-all");
  chk_zero_write_keeps: assert property (
    wr_ok && !clr_all && cpu_req.wdata[FLAG_W-1:0] == FLAG_RESET
    |=> ($past(flags_q) & ~flags_q) == FLAG_RESET)
    else $error("zero write cleared a flag");
  chk_remote_refused: assert property (
    access && !cpu_req.local_cpu |=> cpu_err_q && !cpu_ack_q)
    else $error("remote access not refused");
  chk_halt_request: assert property (
    !halt_line_enable [*2] |-> !cpu_halt_req_q)
    else $error("halt request without enable");
  chk_set_beats_clear: assert property (
    wr_ok && !clr_all && cpu_req.be[0] && cpu_req.wdata[BIT_NOMEM] &&
    dma_no_mem |=> flags_q[BIT_NOMEM])
    else $error("event lost under its clear");

  cov_master_timeout: cover property (mto_exp && mst_demand_q);
  cov_lost_error:     cover property (set_vec[BIT_LOST]);
  cov_clear_by_write: cover property (wr_ok && (clr_vec & flags_q) != '0);
  cov_halted_pg_neg:  cover property (pg_neg && cpu_halted);

endmodule : desf_top
`default_nettype wire

//--- dv/desf_far_model.sv
// Model of the backplane slaves and the bus arbiter facing the flag block.
// Assumes start pulses on ref_clk; answers change at the falling edge.
`timescale 1ns/1ns
`default_nettype none
module desf_far_model (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        mst_start,
  input  wire logic        grant_req,
  input  wire logic [11:0] reply_dly,
  input  wire logic [7:0]  grant_dly,
  input  wire logic        par_err,
  output logic             mst_reply,
  output logic             mst_parity_err,
  output logic             bus_grant
);
  logic [11:0] rc_q;
  logic [7:0]  gc_q;

  // A delay of zero means the far side never answers, which forces a timeout.
  always @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rc_q <= 12'h000;
      gc_q <= 8'h00;
    end
    else
    begin
      rc_q <= mst_start ? reply_dly :
              (rc_q != 12'h000 ? rc_q - 12'h001 : rc_q);
      gc_q <= grant_req ? grant_dly :
              (gc_q != 8'h00 ? gc_q - 8'h01 : gc_q);
    end
  end

  // Answers are one-cycle pulses launched off the falling edge.
  always @(negedge ref_clk)
  begin
    mst_reply      <= (rc_q == 12'h001);
    mst_parity_err <= (rc_q == 12'h001) && par_err;
    bus_grant      <= (gc_q == 8'h01);
  end
endmodule : desf_far_model
`default_nettype wire

//--- dv/desf_top_tb.sv
// Self-checking bench for the error status flags, register side and events.
// Assumes the far model answers master cycles and bus requests.
`timescale 1ns/1ns
`default_nettype none
module desf_top_tb;
  import desf_pkg::*;
  logic ref_clk = 0, rst_n = 0;
  desf_cpu_req_t cpu_req = '0;
  logic [DATA_W-1:0] rd_data_q;
  logic cpu_ack_q, cpu_err_q, cpu_halt_req_q, ipc_err;
  logic halt = 0, pg = 1, hen = 0, dact = 0, halted = 0, iorst = 0;
  logic mst_start = 0, grant_req = 0, mst_reply, par, bus_grant;
  logic mem_err = 0, ext = 0, lmgh = 0, no_mem = 0, perr = 0;
  desf_kind_t  mst_kind = DESF_DEMAND_RD, grant_kind = DESF_DEMAND_RD;
  desf_kind_t  k;
  logic [11:0] rdly = 0;
  logic [7:0]  gdly = 0;
  int bad_count = 0, checked = 0, cycles = 0;

  // The grant wait is shortened so that its timeout fits in the run.
  desf_top #(.NO_GRANT_CYCLES(20)) i_desf_top (.ref_clk(ref_clk),
    .rst_n(rst_n), .cpu_req(cpu_req), .rd_data_q(rd_data_q),
    .cpu_ack_q(cpu_ack_q), .cpu_err_q(cpu_err_q),
    .backplane_halt_line(halt), .backplane_power_good(pg),
    .halt_line_enable(hen), .pg_action_halt(dact), .cpu_halted(halted),
    .io_reset_write(iorst), .mst_start(mst_start), .mst_kind(mst_kind),
    .mst_reply(mst_reply), .mst_parity_err(par), .grant_req(grant_req),
    .grant_kind(grant_kind), .bus_grant(bus_grant), .mem_read_err(mem_err),
    .mem_err_ext_master(ext), .mem_err_lmgh(lmgh), .dma_no_mem(no_mem),
    .cpu_halt_req_q(cpu_halt_req_q),
    .interprocessor_comm_reg_err_q(ipc_err));
  desf_far_model i_desf_far_model (.ref_clk(ref_clk), .rst_n(rst_n),
    .mst_start(mst_start), .grant_req(grant_req), .reply_dly(rdly),
    .grant_dly(gdly), .par_err(perr), .mst_reply(mst_reply),
    .mst_parity_err(par), .bus_grant(bus_grant));

  // Clock and a ceiling well above the expected run of about 20.5k cycles.
  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles > 40000)
    begin
      bad_count++;
      wrap_up();
    end
  end

  task automatic wrap_up();
    $display("checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : wrap_up

  task automatic chk_data(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_data

  task automatic chk_bit(input logic got, input logic exp);
    chk_data({31'h0, got}, {31'h0, exp});
  endtask : chk_bit

  // One read; acknowledge and data stand in the cycle after the request.
  task automatic reg_rd(input logic [31:0] e);
    @(negedge ref_clk) cpu_req = '{1'b1, 1'b1, 1'b0, 1'b1, 4'hf, 32'h0};
    @(negedge ref_clk) cpu_req = '0;
    chk_bit(cpu_ack_q, 1'b1);
    chk_data(rd_data_q, e);
  endtask : reg_rd

  // One write; ev raises a nonexistent memory event in the same cycle.
  task automatic reg_wr(input logic [3:0] be, input logic [31:0] d,
                        input logic loc, input logic ev);
    @(negedge ref_clk) cpu_req = '{1'b1, 1'b0, 1'b1, loc, be, d};
    no_mem = ev;
    @(negedge ref_clk) cpu_req = '0;
    no_mem = 1'b0;
    chk_bit(cpu_ack_q, loc);
    chk_bit(cpu_err_q, !loc);
  endtask : reg_wr

  task automatic mem_fault(input logic e, input logic l);
    @(negedge ref_clk) {mem_err, ext, lmgh} = {1'b1, e, l};
    @(negedge ref_clk) {mem_err, ext, lmgh} = 3'b000;
    chk_bit(ipc_err, e);
  endtask : mem_fault

  // One master cycle or bus request of kind kk, then read and clear.
  task automatic run_kind(input logic g, input desf_kind_t kk,
                          input logic [11:0] d, input logic p,
                          input logic [31:0] e);
    rdly = g ? 12'h000 : d;
    gdly = g ? d[7:0] : 8'h00;
    perr = p;
    @(negedge ref_clk) mst_kind = kk;
    grant_kind = kk;
    {mst_start, grant_req} = {!g, g};
    @(negedge ref_clk) {mst_start, grant_req} = 2'b00;
    repeat (g ? 30 : 2510) @(negedge ref_clk);
    reg_rd(e);
    reg_wr(4'h1, 32'h0000_00bd, 1'b1, 1'b0);
  endtask : run_kind

  // Main sequence: register behaviour first, then events of each source.
  initial
  begin
    repeat (10) @(negedge ref_clk);
    rst_n = 1;
    reg_rd(32'h0000_0000);
    reg_wr(4'h0, 32'h0, 1'b1, 1'b1);
    reg_rd(32'h0000_0001);
    reg_wr(4'h1, 32'h0000_0000, 1'b1, 1'b0);
    reg_rd(32'h0000_0001);
    mem_fault(1'b1, 1'b0);
    reg_rd(32'h0000_0019);
    reg_wr(4'h1, 32'h0000_0019, 1'b0, 1'b0);
    reg_rd(32'h0000_0019);
    reg_wr(4'h1, 32'h0000_00bd, 1'b1, 1'b0);
    reg_rd(32'h0000_0000);
    mem_fault(1'b0, 1'b1);
    reg_wr(4'h2, 32'h0000_0010, 1'b1, 1'b0);
    reg_rd(32'h0000_0010);
    reg_wr(4'h1, 32'h0000_0011, 1'b1, 1'b1);
    reg_rd(32'h0000_0009);
    @(negedge ref_clk) iorst = 1;
    @(negedge ref_clk) iorst = 0;
    reg_rd(32'h0000_0000);
    for (int i = 0; i < 4; i++)
    begin
      k = desf_kind_t'(i);
      run_kind(1'b0, k, 12'd0, 1'b0, i < 2 ? 32'h80 : 32'h0);
      run_kind(1'b0, k, 12'd5, 1'b1, i == 0 ? 32'h20 : 32'h0);
      run_kind(1'b1, k, 12'd0, 1'b0, i < 2 ? 32'h4 : 32'h0);
      run_kind(1'b1, k, 12'd5, 1'b0, 32'h0);
    end
    @(negedge ref_clk) halt = 1;
    repeat (5) @(negedge ref_clk);
    chk_bit(cpu_halt_req_q, 1'b0);
    reg_rd(32'h0000_0000);
    hen = 1;
    repeat (5) @(negedge ref_clk);
    chk_bit(cpu_halt_req_q, 1'b1);
    reg_rd(32'h0000_8000);
    {halt, hen} = 2'b00;
    repeat (5) @(negedge ref_clk);
    reg_wr(4'h2, 32'h0000_8000, 1'b1, 1'b0);
    reg_rd(32'h0000_0000);
    {dact, pg} = 2'b10;
    repeat (6) @(negedge ref_clk);
    reg_rd(32'h0000_4000);
    pg = 1;
    repeat (4) @(negedge ref_clk);
    reg_wr(4'h0, 32'h0, 1'b1, 1'b1);
    {halted, pg} = 2'b10;
    repeat (6) @(negedge ref_clk);
    reg_rd(32'h0000_0000);
    wrap_up();
  end
endmodule : desf_top_tb
`default_nettype wire
